// ### hdl/csd_decoder.sv
// chip-select range decoder top: registers, per-channel decode and mode-switch cycle
`timescale 1ns/10ps

module csd_decoder (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rstn_i,
  // register port
  input  wire logic [csd_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]                     reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [7:0]                     reg_rdata_o,
  // access request from the bus master
  input  wire logic                           acc_valid_i,
  input  wire logic [csd_pkg::ADDR_W-1:0]     acc_addr_i,
  input  wire logic                           acc_io_i,
  // decode results
  output logic      [csd_pkg::NUM_CH-1:0]     mem_sel_o,
  output logic      [csd_pkg::NUM_CH-1:0]     io_sel_o,
  output logic      [1:0]                     acc_mode_o,
  output logic                                acc_hit_o,
  output logic                                acc_done_o,
  output logic                                switch_cycle_o
);

  import csd_pkg::*;

  // =========================================================
  // state
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] low;
    logic [NUM_CH-1:0][7:0] high;
    logic [NUM_CH-1:0][7:0] ctrl;
    logic [NUM_CH-1:0][7:0] mode;
    logic [7:0]             rdata;
    logic [NUM_CH-1:0]      mem_sel;
    logic [NUM_CH-1:0]      io_sel;
    logic [1:0]             acc_mode;
    logic                   acc_hit;
    logic                   acc_done;
    logic                   switch_cyc;
    logic [1:0]             prev_mode;
    logic                   pend;
    logic [1:0]             pend_cnt;
  } csd_state_s;

  csd_state_s s_q;
  csd_state_s s_d;

  // =========================================================
  // per-channel comparators
  logic [NUM_CH-1:0] mem_hit;
  logic [NUM_CH-1:0] io_hit;
  logic [NUM_CH-1:0]      ch_hit;
  logic [NUM_CH-1:0][1:0] ch_mode;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      csd_channel_match u_match (
        .addr_i            (acc_addr_i),
        .range_low_byte_i  (s_q.low[g]),
        .range_high_byte_i (s_q.high[g]),
        .io_space_select_i (s_q.ctrl[g][IO_SPACE_BIT]),
        .select_enable_i   (s_q.ctrl[g][SEL_ENABLE_BIT]),
        .mem_hit_o         (mem_hit[g]),
        .io_hit_o          (io_hit[g])
      );
      // access type picks which comparator counts
      assign ch_hit[g]  = acc_io_i ? io_hit[g] : mem_hit[g];
      assign ch_mode[g] = s_q.mode[g][MODE_LSB +: 2];
    end
  endgenerate

  // =========================================================
  // register address lookup
  typedef enum logic [1:0] {
    CSD_KIND_LOW,
    CSD_KIND_HIGH,
    CSD_KIND_CTRL,
    CSD_KIND_MODE
  } csd_kind_e;

  typedef struct packed {
    logic       valid;
    csd_kind_e  kind;
    logic [1:0] ch;
    logic [7:0] wmask;
  } csd_regsel_s;

  // one entry per address, so the map never leans on address ordering
  function automatic csd_regsel_s reg_lookup(input logic [7:0] a);
    csd_regsel_s r;
    r = '0;
    unique case (a)
      RANGE_LOW_CH0: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_LOW;
        r.ch    = 2'h0;
        r.wmask = 8'hff;
      end
      RANGE_HIGH_CH0: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_HIGH;
        r.ch    = 2'h0;
        r.wmask = 8'hff;
      end
      SEL_CTRL_CH0: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_CTRL;
        r.ch    = 2'h0;
        r.wmask = CTRL_WMASK;
      end
      RANGE_LOW_CH1: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_LOW;
        r.ch    = 2'h1;
        r.wmask = 8'hff;
      end
      RANGE_HIGH_CH1: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_HIGH;
        r.ch    = 2'h1;
        r.wmask = 8'hff;
      end
      SEL_CTRL_CH1: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_CTRL;
        r.ch    = 2'h1;
        r.wmask = CTRL_WMASK;
      end
      RANGE_LOW_CH2: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_LOW;
        r.ch    = 2'h2;
        r.wmask = 8'hff;
      end
      RANGE_HIGH_CH2: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_HIGH;
        r.ch    = 2'h2;
        r.wmask = 8'hff;
      end
      SEL_CTRL_CH2: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_CTRL;
        r.ch    = 2'h2;
        r.wmask = CTRL_WMASK;
      end
      RANGE_LOW_CH3: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_LOW;
        r.ch    = 2'h3;
        r.wmask = 8'hff;
      end
      RANGE_HIGH_CH3: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_HIGH;
        r.ch    = 2'h3;
        r.wmask = 8'hff;
      end
      SEL_CTRL_CH3: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_CTRL;
        r.ch    = 2'h3;
        r.wmask = CTRL_WMASK;
      end
      BUS_MODE_CH0: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_MODE;
        r.ch    = 2'h0;
        r.wmask = MODE_WMASK;
      end
      BUS_MODE_CH1: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_MODE;
        r.ch    = 2'h1;
        r.wmask = MODE_WMASK;
      end
      BUS_MODE_CH2: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_MODE;
        r.ch    = 2'h2;
        r.wmask = MODE_WMASK;
      end
      BUS_MODE_CH3: begin
        r.valid = 1'b1;
        r.kind  = CSD_KIND_MODE;
        r.ch    = 2'h3;
        r.wmask = MODE_WMASK;
      end
      default: begin
        r.valid = 1'b0;
        r.kind  = CSD_KIND_LOW;
        r.ch    = 2'h0;
        r.wmask = 8'h00;
      end
    endcase
    return r;
  endfunction : reg_lookup

  // =========================================================
  // next state
  csd_regsel_s       rsel;
  logic [NUM_CH-1:0] hit_vec;
  logic [1:0]        new_mode;
  logic              new_is_strobe;
  logic              mode_changed;
  logic              prev_not_legacy;
  logic              need_switch;
  logic              any_hit;

  always_comb begin
    s_d         = s_q;
    rsel        = reg_lookup(reg_addr_i);
    hit_vec     = '0;
    new_mode    = CSD_MODE_NATIVE;
    need_switch = 1'b0;
    any_hit     = 1'b0;

    // register writes
    if (reg_wr_i && rsel.valid) begin
      unique case (rsel.kind)
        CSD_KIND_LOW:  s_d.low[rsel.ch]  = reg_wdata_i & rsel.wmask;
        CSD_KIND_HIGH: s_d.high[rsel.ch] = reg_wdata_i & rsel.wmask;
        CSD_KIND_CTRL: s_d.ctrl[rsel.ch] = reg_wdata_i & rsel.wmask;
        CSD_KIND_MODE: s_d.mode[rsel.ch] = reg_wdata_i & rsel.wmask;
      endcase
    end

    // register reads: data in the next cycle only, unmapped reads zero
    s_d.rdata = 8'h00;
    if (reg_rd_i && rsel.valid) begin
      unique case (rsel.kind)
        CSD_KIND_LOW:  s_d.rdata = s_q.low[rsel.ch];
        CSD_KIND_HIGH: s_d.rdata = s_q.high[rsel.ch];
        CSD_KIND_CTRL: s_d.rdata = s_q.ctrl[rsel.ch];
        CSD_KIND_MODE: s_d.rdata = s_q.mode[rsel.ch];
      endcase
    end

    // decode defaults: selects answer an access for one cycle, or two when a switch cycle holds them
    s_d.mem_sel    = '0;
    s_d.io_sel     = '0;
    s_d.acc_hit    = 1'b0;
    s_d.acc_done   = 1'b0;
    s_d.switch_cyc = 1'b0;

    // lowest channel wins when windows overlap
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (ch_hit[i]) begin
        hit_vec  = '0;
        hit_vec[i] = 1'b1;
        new_mode = ch_mode[i];
      end
    end
    any_hit = |hit_vec;

    // only strobe styles pay the switch cycle, and only on a real change
    new_is_strobe   = (new_mode == CSD_MODE_RWSTB) | (new_mode == CSD_MODE_ADSTB);
    mode_changed    = (new_mode != s_q.prev_mode);
    prev_not_legacy = (s_q.prev_mode != CSD_MODE_LEGACY);
    need_switch     = any_hit & new_is_strobe & mode_changed & prev_not_legacy;

    if (s_q.pend) begin
      // extra cycle running: hold the selects, finish when count drains
      s_d.switch_cyc = 1'b0;
      s_d.pend_cnt   = s_q.pend_cnt - 2'h1;
      if (s_q.pend_cnt == 2'h1) begin
        s_d.pend     = 1'b0;
        s_d.acc_done = 1'b1;
      end
      s_d.mem_sel = s_q.mem_sel;
      s_d.io_sel  = s_q.io_sel;
      s_d.acc_hit = s_q.acc_hit;
    end else if (acc_valid_i) begin
      s_d.mem_sel  = acc_io_i ? '0 : hit_vec;
      s_d.io_sel   = acc_io_i ? hit_vec : '0;
      s_d.acc_hit  = any_hit;
      s_d.acc_mode = any_hit ? new_mode : CSD_MODE_NATIVE;
      if (any_hit) begin
        s_d.prev_mode = new_mode;
      end
      if (need_switch) begin
        s_d.switch_cyc = 1'b1;
        s_d.pend       = 1'b1;
        s_d.pend_cnt   = SWITCH_CYCLES;
      end else begin
        s_d.acc_done = 1'b1;
      end
    end

    // synchronous reset
    if (!rstn_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        s_d.low[i]  = RANGE_LOW_RST;
        s_d.high[i] = (i == 0) ? RANGE_HIGH0_RST : RANGE_HIGH_RST;
        s_d.ctrl[i] = (i == 0) ? CTRL0_RST : CTRL_RST;
        s_d.mode[i] = MODE_REG_RST;
      end
      s_d.rdata      = 8'h00;
      s_d.mem_sel    = '0;
      s_d.io_sel     = '0;
      s_d.acc_mode   = CSD_MODE_NATIVE;
      s_d.acc_hit    = 1'b0;
      s_d.acc_done   = 1'b0;
      s_d.switch_cyc = 1'b0;
      s_d.prev_mode  = CSD_MODE_NATIVE;
      s_d.pend       = 1'b0;
      s_d.pend_cnt   = 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // =========================================================
  // outputs
  assign reg_rdata_o    = s_q.rdata;
  assign mem_sel_o      = s_q.mem_sel;
  assign io_sel_o       = s_q.io_sel;
  assign acc_mode_o     = s_q.acc_mode;
  assign acc_hit_o      = s_q.acc_hit;
  assign acc_done_o     = s_q.acc_done;
  assign switch_cycle_o = s_q.switch_cyc;

endmodule : csd_decoder

// ### hdl/csd_pkg.sv
// package: register map, field positions, reset values and modes for the chip-select decoder
package csd_pkg;

  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned REG_ADDR_W = 8;

  // register byte addresses (one byte register per address on the plain port)
  localparam logic [7:0] RANGE_LOW_CH0  = 8'ha8;
  localparam logic [7:0] RANGE_HIGH_CH0 = 8'ha9;
  localparam logic [7:0] SEL_CTRL_CH0   = 8'haa;
  localparam logic [7:0] RANGE_LOW_CH1  = 8'hab;
  localparam logic [7:0] RANGE_HIGH_CH1 = 8'hac;
  localparam logic [7:0] SEL_CTRL_CH1   = 8'had;
  localparam logic [7:0] RANGE_LOW_CH2  = 8'hae;
  localparam logic [7:0] RANGE_HIGH_CH2 = 8'haf;
  localparam logic [7:0] SEL_CTRL_CH2   = 8'hb0;
  localparam logic [7:0] RANGE_LOW_CH3  = 8'hb1;
  localparam logic [7:0] RANGE_HIGH_CH3 = 8'hb2;
  localparam logic [7:0] SEL_CTRL_CH3   = 8'hb3;
  localparam logic [7:0] BUS_MODE_CH0   = 8'hf0;
  localparam logic [7:0] BUS_MODE_CH1   = 8'hf1;
  localparam logic [7:0] BUS_MODE_CH2   = 8'hf2;
  localparam logic [7:0] BUS_MODE_CH3   = 8'hf3;

  // field positions
  localparam int unsigned IO_SPACE_BIT   = 4;
  localparam int unsigned SEL_ENABLE_BIT = 3;
  localparam int unsigned MODE_LSB       = 6;
  localparam int unsigned CTRL_RW_LSB    = 3;

  // reset values
  localparam logic [7:0] RANGE_LOW_RST   = 8'h00;
  localparam logic [7:0] RANGE_HIGH0_RST = 8'hff;
  localparam logic [7:0] RANGE_HIGH_RST  = 8'h00;
  localparam logic [7:0] CTRL0_RST       = 8'he8;
  localparam logic [7:0] CTRL_RST        = 8'h00;
  localparam logic [7:0] MODE_REG_RST    = 8'h02;

  // writable masks (reserved bits read zero)
  localparam logic [7:0] CTRL_WMASK = 8'hf8;
  localparam logic [7:0] MODE_WMASK = 8'hef;

  // extra cycle added on a mode switch
  localparam logic [1:0] SWITCH_CYCLES = 2'h1;

  typedef enum logic [1:0] {
    CSD_MODE_NATIVE = 2'b00,
    CSD_MODE_LEGACY = 2'b01,
    CSD_MODE_RWSTB  = 2'b10,
    CSD_MODE_ADSTB  = 2'b11
  } csd_mode_e;

endpackage : csd_pkg

// ### hdl/csd_channel_match.sv
// one channel's address comparator for memory or i/o select
`timescale 1ns/10ps
module csd_channel_match (
  // address
  input  wire logic [csd_pkg::ADDR_W-1:0] addr_i,
  // channel configuration
  input  wire logic [7:0]                 range_low_byte_i,
  input  wire logic [7:0]                 range_high_byte_i,
  input  wire logic                       io_space_select_i,
  input  wire logic                       select_enable_i,
  // decision
  output logic                            mem_hit_o,
  output logic                            io_hit_o
);

  import csd_pkg::*;

  logic [7:0] top_byte;
  logic [7:0] mid_byte;

  assign top_byte  = addr_i[23:16];
  assign mid_byte  = addr_i[15:8];
  // memory window inclusive on both ends, upper bound unused for i/o
  assign mem_hit_o = select_enable_i & ~io_space_select_i
                   & (top_byte >= range_low_byte_i)
                   & (top_byte <= range_high_byte_i);
  assign io_hit_o  = select_enable_i & io_space_select_i
                   & (mid_byte == range_low_byte_i);

endmodule : csd_channel_match

// ### testbench/csd_props.sv
// checker: timing relations at the decoder ports
`timescale 1ns/10ps
module csd_props (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  // access side
  input wire logic                       acc_valid_i,
  input wire logic                       acc_io_i,
  input wire logic [csd_pkg::NUM_CH-1:0] mem_sel_o,
  input wire logic [csd_pkg::NUM_CH-1:0] io_sel_o,
  input wire logic [1:0]                 acc_mode_o,
  input wire logic                       acc_hit_o,
  input wire logic                       acc_done_o,
  input wire logic                       switch_cycle_o
);
  import csd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================
  // assertions
  take_once_a: assert property (acc_valid_i && !switch_cycle_o |=> acc_done_o != switch_cycle_o)
    else $error("access not answered by done or switch");
  switch_done_a: assert property (switch_cycle_o |=> acc_done_o && !switch_cycle_o)
    else $error("switch cycle longer than one cycle");
  switch_hold_a: assert property (switch_cycle_o |=> $stable(mem_sel_o) && $stable(io_sel_o) && acc_hit_o)
    else $error("select changed during switch cycle");
  switch_mode_a: assert property (switch_cycle_o |-> acc_mode_o[1])
    else $error("switch cycle into a non-strobe mode");
  sel_onehot_a: assert property (acc_hit_o == (|{mem_sel_o, io_sel_o}) && $onehot0({mem_sel_o, io_sel_o}))
    else $error("hit and selects disagree");
  io_only_a: assert property (acc_valid_i && !switch_cycle_o && acc_io_i |=> mem_sel_o == '0)
    else $error("memory select on i/o access");
  mem_only_a: assert property (acc_valid_i && !switch_cycle_o && !acc_io_i |=> io_sel_o == '0)
    else $error("i/o select on memory access");
  idle_quiet_a: assert property (!acc_valid_i && !switch_cycle_o |=> !acc_hit_o && !acc_done_o)
    else $error("select without access");
  sw_c: cover property (switch_cycle_o);
  io_c: cover property (|io_sel_o);
  mem_c: cover property (|mem_sel_o);
endmodule : csd_props
bind csd_decoder csd_props u_props (.clk_i, .rstn_i, .acc_valid_i, .acc_io_i, .mem_sel_o, .io_sel_o,
  .acc_mode_o, .acc_hit_o, .acc_done_o, .switch_cycle_o);

// ### testbench/csd_periph.sv
// far side: selected devices counting the accesses they served
`timescale 1ns/10ps
module csd_periph (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // bus side
  input  wire logic        hit_i,
  input  wire logic        done_i,
  output logic      [15:0] served_o
);
  // count at done so a stretched select counts once
  always_ff @(posedge clk_i) begin
    if (!rstn_i) served_o <= 16'h0;
    else if (hit_i && done_i) served_o <= served_o + 16'h1;
  end
endmodule : csd_periph

// ### testbench/tb.sv
// testbench: register, decode and mode-switch checks against a behavioural model
`timescale 1ns/10ps
module tb;
  import csd_pkg::*;
  logic clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, acc_valid_i = 0, acc_io_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [23:0] acc_addr_i = 0;
  logic [3:0] mem_sel_o, io_sel_o;
  logic [1:0] acc_mode_o, em = 0;
  logic acc_hit_o, acc_done_o, switch_cycle_o;
  logic [15:0] served;
  logic [7:0] rm [256];
  logic [31:0] rs = 10367;
  int bad_count = 0, checked = 0, prev = 0, hits = 0;
  always #10 clk_i = ~clk_i;
  csd_decoder dut (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .acc_valid_i, .acc_addr_i, .acc_io_i, .mem_sel_o, .io_sel_o, .acc_mode_o, .acc_hit_o,
    .acc_done_o, .switch_cycle_o);
  csd_periph u_far (.clk_i, .rstn_i, .hit_i(acc_hit_o), .done_i(acc_done_o), .served_o(served));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // =========================================
  // register port
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 0;
    if (a inside {[8'ha8:8'hb3]}) rm[a] = (a - 8'ha8) % 3 == 2 ? d & CTRL_WMASK : d;
    if (a inside {[8'hf0:8'hf3]}) rm[a] = d & MODE_WMASK;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 chk("reg", rm[a], reg_rdata_o);
  endtask : rd
  // =========================================
  // access with expectation from the model
  task automatic acc(logic [23:0] a, logic io);
    int c, m;
    logic [3:0] es;
    logic sw;
    logic [7:0] lo, hi, ct;
    c = -1;
    for (int i = 3; i >= 0; i--) begin
      lo = rm[8'ha8 + 3 * i];
      hi = rm[8'ha9 + 3 * i];
      ct = rm[8'haa + 3 * i];
      if (ct[3] && (io ? ct[4] && a[15:8] == lo : !ct[4] && a[23:16] >= lo && a[23:16] <= hi)) c = i;
    end
    es = c < 0 ? 4'h0 : 4'h1 << c;
    m = c < 0 ? prev : rm[8'hf0 + c] >> 6;
    sw = c >= 0 && m >= 2 && m != prev && prev != 1;
    em = c < 0 ? 2'h0 : 2'(m);
    if (c >= 0) begin
      prev = m;
      hits++;
    end
    @(posedge clk_i);
    acc_valid_i <= 1;
    acc_addr_i <= a;
    acc_io_i <= io;
    @(posedge clk_i);
    acc_valid_i <= 0;
    #1 chk("mem_sel", io ? 8'h00 : 8'(es), 8'(mem_sel_o));
    chk("io_sel", io ? 8'(es) : 8'h00, 8'(io_sel_o));
    chk("hit", 8'(c >= 0), 8'(acc_hit_o));
    chk("switch", 8'(sw), 8'(switch_cycle_o));
    chk("done", 8'(!sw), 8'(acc_done_o));
    chk("mode", 8'(em), 8'(acc_mode_o));
    if (sw) begin
      @(posedge clk_i);
      #1 chk("done2", 8'h01, 8'(acc_done_o));
      chk("switch2", 8'h00, 8'(switch_cycle_o));
    end
  endtask : acc
  initial begin
    #1ms;
    bad_count++;
    conclude();
  end
  initial begin
    int c;
    logic [7:0] b;
    for (int i = 0; i < 256; i++) rm[i] = 0;
    rm[8'ha9] = 8'hff;
    rm[8'haa] = 8'he8;
    for (int i = 0; i < 4; i++) rm[8'hf0 + i] = 8'h02;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1;
    repeat (2) @(posedge clk_i);
    for (int i = 8'ha6; i < 8'hb5; i++) rd(8'(i));
    for (int i = 8'hf0; i < 8'hf5; i++) rd(8'(i));
    // every mode pair through channel 0, all addresses in its window
    for (int i = 0; i < 16; i++) begin
      wr(8'hf0, 8'((i >> 2) << 6));
      acc(24'(rnd()), 1'b0);
      wr(8'hf0, 8'((i & 3) << 6));
      acc(24'(rnd()), 1'b0);
    end
    // random configuration, addresses near the bounds
    for (int k = 0; k < 400; k++) begin
      c = int'(rnd() % 4);
      case (rnd() % 6)
        0: wr(8'(8'ha8 + 3 * c), 8'(rnd()));
        1: wr(8'(8'ha9 + 3 * c), 8'(rnd()));
        2: wr(8'(8'haa + 3 * c), 8'(rnd() & CTRL_WMASK));
        3: wr(8'(8'hf0 + c), 8'(rnd() & MODE_WMASK));
        4: wr(8'h40, 8'(rnd()));
        default: rd(rnd() % 2 ? 8'h40 : 8'(8'ha8 + rnd() % 12));
      endcase
      b = 8'(rm[8'ha8 + 3 * c + rnd() % 2] + (rnd() % 3) - 1);
      acc({b, b, 8'(rnd())} ^ {rnd() % 4 == 0 ? 8'(rnd()) : 8'h0, 16'h0}, 1'(rnd() % 2));
    end
    // the far side counts one edge after done
    repeat (2) @(posedge clk_i);
    #1 chk("served", 8'(hits), served[7:0]);
    conclude();
  end
endmodule : tb
